// [rtl/rsp_frame_port.sv]
// rheostat serial frame port: frame receive, wiper update, readback shift-out
// assumes serial pins asynchronous to clk, serial clock far slower than clk
`timescale 1ns/1ns
`include "rsp_cfg.svh"
module rsp_frame_port
	import rsp_pkg::*;
(
	// clock and control
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// serial pins
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic din,
	input wire logic serial_out_od_i,
	output logic serial_out_od_o,
	output logic serial_out_od_oe_n,
	// wiper state
	output rsp_wiper_t wiper_register,
	output logic wiper_update
);
	typedef enum logic [1:0] {
		RSP_IDLE = 2'b01,
		RSP_SHIFT = 2'b10
	} rsp_state_t;

	rsp_pins_if pins ();

	rsp_pin_sync u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.sclk_pin(sclk),
		.sel_n_pin(sel_n),
		.din_pin(din),
		.pins(pins)
	);

	rsp_state_t state_reg, state_next;
	rsp_frame_t shift_reg, shift_next;
	logic [`RSP_CNT_BITS-1:0] cnt_reg, cnt_next;
	logic full_reg, full_next;
	rsp_wiper_t wiper_reg, wiper_next;
	logic upd_reg, upd_next;
	logic rd_pend_reg, rd_pend_next;
	logic out_reg, out_next;
	rsp_cmd_t cmd;

	assign cmd = shift_reg[`RSP_CMD_MSB:`RSP_CMD_LSB];

	always_comb
	begin
		state_next = state_reg;
		shift_next = shift_reg;
		cnt_next = cnt_reg;
		full_next = full_reg;
		wiper_next = wiper_reg;
		upd_next = 1'b0;
		rd_pend_next = rd_pend_reg;
		out_next = out_reg;
		case (state_reg)
			RSP_IDLE:
			begin
				out_next = 1'b1;
				if (!pins.sel_n)
				begin
					// frame opens; readback data preloaded into low bits
					state_next = RSP_SHIFT;
					cnt_next = '0;
					full_next = 1'b0;
					if (rd_pend_reg)
					begin
						shift_next = {6'h00, wiper_reg};
						rd_pend_next = 1'b0;
					end
					out_next = shift_next[`RSP_FRAME_BITS-1];
				end
			end
			RSP_SHIFT:
			begin
				if (pins.sel_rise)
				begin
					state_next = RSP_IDLE;
					out_next = 1'b1;
					// only whole multiples of sixteen clocks commit
					if (full_reg && cnt_reg == '0)
					begin
						if (cmd == `RSP_CMD_WRITE)
						begin
							wiper_next = shift_reg[`RSP_DATA_BITS-1:0];
							upd_next = 1'b1;
						end
						else if (cmd == `RSP_CMD_READ)
							rd_pend_next = 1'b1;
					end
					// otherwise partial frame dropped
				end
				else if (pins.sclk_fall)
				begin
					shift_next = {shift_reg[`RSP_FRAME_BITS-2:0], pins.din};
					cnt_next = cnt_reg + 4'h1;
					if (cnt_reg == `RSP_CNT_LAST)
						full_next = 1'b1;
					// msb leaves after each shift, for cascading
					out_next = shift_next[`RSP_FRAME_BITS-1];
				end
			end
			default:
			begin
				state_next = RSP_IDLE;
				out_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_reg <= RSP_IDLE;
			shift_reg <= 16'h0000;
			cnt_reg <= 4'h0;
			full_reg <= 1'b0;
			wiper_reg <= `RSP_WIPER_RESET;
			upd_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			out_reg <= 1'b1;
		end
		else if (clk_en)
		begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			cnt_reg <= cnt_next;
			full_reg <= full_next;
			wiper_reg <= wiper_next;
			upd_reg <= upd_next;
			rd_pend_reg <= rd_pend_next;
			out_reg <= out_next;
		end
	end

	// open drain: pull low only, otherwise released to the host pull-up
	assign serial_out_od_o = 1'b0;
	assign serial_out_od_oe_n = out_reg | pins.sel_n;
	assign wiper_register = wiper_reg;
	assign wiper_update = upd_reg;
endmodule : rsp_frame_port

// [rtl/rsp_cfg.svh]
// rheostat serial frame port constants: frame layout, commands, widths
// assumes inclusion by bare name from rtl files
//
// Overview of operation
// - sample serial input on serial clock falling edges
// - shift register enabled only while select low
// - update register on select rise after a whole multiple of sixteen clocks
// - short frame on select rise is discarded
// - sixteen-bit input shift register holds frame
// - shift register contents leave on serial output
// - serial output open drain, host pulls up
// - frame: two zeros, four command, ten data
// - bit counter counts serial clocks modulo sixteen
// - command one loads wiper, zero does nothing
// - wiper readback in last ten clocks next frame
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
`define RSP_FRAME_BITS 16
`define RSP_CNT_BITS 4
`define RSP_CNT_LAST 4'hf
`define RSP_PIN_IDLE 3'h2
`define RSP_DATA_BITS 10
`define RSP_CMD_MSB 13
`define RSP_CMD_LSB 10
`define RSP_CMD_NOP 4'h0
`define RSP_CMD_WRITE 4'h1
`define RSP_CMD_READ 4'h2
`define RSP_WIPER_RESET 10'h200
`endif

// [rtl/rsp_pkg.sv]
// rheostat serial frame port types
// assumes rsp_cfg.svh alongside
`include "rsp_cfg.svh"
package rsp_pkg;
	typedef logic [`RSP_FRAME_BITS-1:0] rsp_frame_t;
	typedef logic [`RSP_DATA_BITS-1:0] rsp_wiper_t;
	typedef logic [`RSP_CMD_MSB-`RSP_CMD_LSB:0] rsp_cmd_t;
endpackage : rsp_pkg

// [rtl/rsp_pins_if.sv]
// synchronised pin bundle between the pin filter and the frame logic
// assumes one clock domain, clk
`timescale 1ns/1ns
interface rsp_pins_if;
	logic sel_n;
	logic sclk_fall;
	logic sel_rise;
	logic din;
	modport src (output sel_n, output sclk_fall, output sel_rise, output din);
	modport dst (input sel_n, input sclk_fall, input sel_rise, input din);
endinterface : rsp_pins_if

// [rtl/rsp_pin_sync.sv]
// three-stage synchronisers for the serial pins plus edge detection
// assumes pins are asynchronous to clk; edges count once stages two and three agree
`timescale 1ns/1ns
`include "rsp_cfg.svh"
module rsp_pin_sync
	import rsp_pkg::*;
(
	// clock and control
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// raw pins
	input wire logic sclk_pin,
	input wire logic sel_n_pin,
	input wire logic din_pin,
	// filtered outputs
	rsp_pins_if.src pins
);
	logic [2:0] s1_reg, s1_next;
	logic [2:0] s2_reg, s2_next;
	logic [2:0] s3_reg, s3_next;
	logic [2:0] st_reg, st_next;
	logic [2:0] raw;
	logic [2:0] fall, rise;

	assign raw = {din_pin, sel_n_pin, sclk_pin};

	always_comb
	begin
		s1_next = raw;
		s2_next = s1_reg;
		s3_next = s2_reg;
		st_next = st_reg;
		for (int i = 0; i < 3; i++)
		begin
			// stable value updates only when stages two and three agree
			if (s2_reg[i] == s3_reg[i])
				st_next[i] = s3_reg[i];
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			// idle pin levels, so leaving reset shows no false clock edge
			s1_reg <= `RSP_PIN_IDLE;
			s2_reg <= `RSP_PIN_IDLE;
			s3_reg <= `RSP_PIN_IDLE;
			st_reg <= `RSP_PIN_IDLE;
		end
		else if (clk_en)
		begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			st_reg <= st_next;
		end
	end

	assign fall = st_reg & ~st_next;
	assign rise = ~st_reg & st_next;
	assign pins.sclk_fall = fall[0] & clk_en;
	assign pins.sel_rise = rise[1] & clk_en;
	assign pins.sel_n = st_reg[1];
	assign pins.din = st_next[2];
endmodule : rsp_pin_sync

// [tb/rsp_frame_port_sva.sv]
// pin checks for the frame port
// assumes bind onto rsp_frame_port; clk_en drops only between frames
`timescale 1ns/1ns
`include "rsp_cfg.svh"
module rsp_frame_port_sva
	import rsp_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic serial_out_od_o,
	input wire logic serial_out_od_oe_n,
	input rsp_wiper_t wiper_register,
	input wire logic wiper_update
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// six covers the three sync stages plus the output flop
	sequence s_idle; sel_n[*6]; endsequence
	sequence s_quiet; (!sel_n && $stable(sclk))[*8]; endsequence
	AST_OD_LOW: assert property (serial_out_od_o == 1'b0) else $error("od");
	AST_IDLE: assert property (s_idle |-> serial_out_od_oe_n) else $error("idle");
	AST_STEADY: assert property (s_quiet |-> $stable(serial_out_od_oe_n)) else $error("out");
	AST_TIE: assert property ($changed(wiper_register) |-> wiper_update) else $error("tie");
	AST_ONE: assert property (wiper_update |=> !wiper_update) else $error("one");
	AST_SEL: assert property (wiper_update |-> sel_n && $past(sel_n, 3)) else $error("sel");
	AST_HOLD: assert property (!sel_n && !$past(sel_n) |-> $stable(wiper_register))
		else $error("hold");
	AST_RST: assert property (disable iff (1'b0) sys_rst |=> wiper_register == `RSP_WIPER_RESET
		&& serial_out_od_oe_n) else $error("rst");
endmodule : rsp_frame_port_sva
bind rsp_frame_port rsp_frame_port_sva u_sva (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
	.sel_n(sel_n), .serial_out_od_o(serial_out_od_o), .serial_out_od_oe_n(serial_out_od_oe_n),
	.wiper_register(wiper_register), .wiper_update(wiper_update));

// [tb/rsp_host_model.sv]
// serial host model: frames on sclk, sel_n, din
// assumes line is the pulled-up output
`timescale 1ns/1ns
module rsp_host_model
(
	// link pins
	input wire logic clk,
	input wire logic line,
	output logic sclk = 1'b0,
	output logic sel_n = 1'b1,
	output logic din = 1'b0
);
	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk
	// four clk a half period gives the 800 ns link clock
	task automatic xfer(input logic [31:0] f, input int n, output logic [15:0] rd);
		rd = '0;
		sel_n <= 1'b0;
		// long setup gives the output time to settle before the first clock
		tk(12);
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk <= 1'b1;
			din <= f[i];
			tk(4);
			rd = {rd[14:0], line};
			sclk <= 1'b0;
			tk(4);
		end
		sel_n <= 1'b1;
		din <= ~din;
		tk(16);
	endtask : xfer
endmodule : rsp_host_model

// [tb/tb.sv]
// bench for the rheostat frame port
// assumes host model and checker beside it
`timescale 1ns/1ns
module tb;
	import rsp_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	wire sclk, sel_n, din;
	logic od_o, oe_n, upd;
	rsp_wiper_t wiper;
	logic [15:0] rd;
	int n_mismatch = 0;
	int total_checks = 0;
	int cyc = 0;
	int n_upd = 0;
	wire line = oe_n ? 1'b1 : od_o; // pull-up
	always #50 clk = ~clk;
	rsp_frame_port uut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sclk(sclk),
		.sel_n(sel_n), .din(din), .serial_out_od_i(line), .serial_out_od_o(od_o),
		.serial_out_od_oe_n(oe_n), .wiper_register(wiper), .wiper_update(upd));
	rsp_host_model host (.clk(clk), .line(line), .sclk(sclk), .sel_n(sel_n), .din(din));
	// counts update pulses, so a dropped frame that still pulses is caught
	always @(posedge clk)
	begin
		if (upd === 1'b1)
			n_upd <= n_upd + 1;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic t_write;
		host.xfer(32'h000007a5, 16, rd);
		chk({6'h00, wiper}, 16'h03a5);
	endtask : t_write
	// short, idle-command and odd-length frames
	task automatic t_drop;
		host.xfer(32'h00000411, 15, rd);
		chk({6'h00, wiper}, 16'h03a5);
		host.xfer(32'h00000011, 16, rd);
		chk({6'h00, wiper}, 16'h03a5);
		host.xfer(32'h04110411, 31, rd);
		chk({6'h00, wiper}, 16'h03a5);
		chk(n_upd[15:0], 16'h0001);
	endtask : t_drop
	// clk_en low must freeze the port through a whole write frame
	task automatic t_freeze;
		clk_en <= 1'b0;
		host.xfer(32'h000004aa, 16, rd);
		clk_en <= 1'b1;
		repeat (8) @(posedge clk);
		chk({6'h00, wiper}, 16'h0155);
		chk(n_upd[15:0], 16'h0002);
	endtask : t_freeze
	// mid-run reset returns midscale and releases the output
	task automatic t_reset;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk({oe_n, 5'h00, wiper}, 16'h8200);
		host.xfer(32'h000007a5, 16, rd);
		chk({6'h00, wiper}, 16'h03a5);
	endtask : t_reset
	task automatic t_read;
		host.xfer(32'h00000555, 32, rd);
		chk({6'h00, wiper}, 16'h0155);
		host.xfer(32'h00000800, 16, rd);
		host.xfer(32'h00000000, 16, rd);
		chk(rd, 16'h0155);
	endtask : t_read
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_mismatch++;
			end_of_test;
		end
	end
	initial
	begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk({oe_n, 5'h00, wiper}, 16'h8200);
		t_write;
		t_drop;
		t_read;
		t_freeze;
		t_reset;
		end_of_test;
	end
endmodule : tb
